// *** include/fault_supervisor_consts.vh ***
`ifndef FAULT_SUPERVISOR_CONSTS_VH
`define FAULT_SUPERVISOR_CONSTS_VH
`define CLK_HZ 50000000
`define T_BLOWER_MS 3000
`define T_HEATER_MS 2000
`define T_BIAS_MS 2000
`define T_LOWV_MS 300
`define T_BIASRUN_MS 2000
`define CYC_PER_MS (`CLK_HZ / 1000)
`define CODE_NONE 8'h00
`define CODE_LOCK 8'h01
`define CODE_VSWR 8'h02
`define CODE_RECYC 8'h04
`define CODE_HOFF 8'h0A
`define CODE_PHASE 8'h0B
`define CODE_AIR 8'h0C
`define CODE_HEATV 8'h0D
`define CODE_DRV 8'h0E
`define CODE_POFF 8'h14
`define CODE_OVLD 8'h15
`define CODE_BIAS 8'h16
`define CODE_STEPI 8'h17
`define CODE_LOWV 8'h18
`define CODE_BIASRUN 8'h1E
`define PADDR_CODE 12'h000
`define PADDR_STAT 12'h004
`define PADDR_MASK 12'h008
`define PADDR_MENU 12'h00C
`define PADDR_EVT 12'h010
`define PADDR_KEY 12'h014
`define MENU_FIL 3'h5
`define MENU_CAUSE 3'h6
`define MENU_LAST 3'h6
`define KEY_NEXT 0
`define KEY_PREV 1
`define KEY_SEL 2
`define KEY_CLR 3
`define KEY_RET 4
`endif

// *** src/transmitter_fault_supervisor.v ***
`timescale 1ns/1ps
`include "fault_supervisor_consts.vh"
module transmitter_fault_supervisor #(
  parameter T_BLOWER_CYC = `T_BLOWER_MS * `CYC_PER_MS,
  parameter T_HEATER_CYC = `T_HEATER_MS * `CYC_PER_MS,
  parameter T_BIAS_CYC = `T_BIAS_MS * `CYC_PER_MS,
  parameter T_LOWV_CYC = `T_LOWV_MS * `CYC_PER_MS,
  parameter T_BIASRUN_CYC = `T_BIASRUN_MS * `CYC_PER_MS,
  parameter DEPTH = 8
) (
  input wire ref_clk_i,
  input wire rst_n_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  output reg [31:0] prdata_o,
  output reg pready_o,
  output reg pslverr_o,
  input wire fil_seq_i,
  input wire plate_seq_i,
  input wire step_seq_i,
  input wire run_i,
  input wire freq_lock_fail_i,
  input wire vswr_high_i,
  input wire auto_power_i,
  input wire recycle_over_i,
  input wire heater_off_button_i,
  input wire plate_off_button_i,
  input wire phase_open_i,
  input wire blower_on_i,
  input wire air_closed_i,
  input wire heater_power_on_i,
  input wire heater_above_5v_i,
  input wire driver_stage_low_i,
  input wire ovld_open_i,
  input wire bias_on_i,
  input wire bias_below_150_i,
  input wire step_only_i,
  input wire plate_i_above_3a_i,
  input wire plate_v_below_6kv_i,
  input wire [15:0] overload_evt_i,
  input wire [2:0] overload_type_i,
  input wire overload_stb_i,
  output reg [7:0] fault_code_o,
  output reg fault_stb_o,
  output reg [2:0] menu_entry_o,
  output reg [15:0] menu_value_o,
  output reg irq_o
);
  reg [31:0] cnt_air_r, cnt_heat_r, cnt_bias_r, cnt_lowv_r, cnt_run_r;
  reg blower_d_r, heat_d_r, bias_d_r;
  reg [7:0] code_r;
  reg [7:0] det_nxt;
  reg [15:0] hist_r [0:`MENU_LAST*DEPTH-1];
  reg [2:0] wptr_r [0:`MENU_LAST-1];
  reg [3:0] cnt_r [0:`MENU_LAST-1];
  reg [2:0] view_r;
  reg [2:0] menu_r;
  reg clr_arm_r;
  reg [1:0] stat_r, mask_r;
  wire apb_wr = psel_i & penable_i & pwrite_i;
  wire apb_rd = psel_i & penable_i & ~pwrite_i;
  wire [4:0] key = pwdata_i[4:0];
  wire key_wr = apb_wr & (paddr_i == `PADDR_KEY);
  integer i;

  function [7:0] digits;
    input [7:0] c;
    reg [7:0] tens;
    reg [7:0] ones;
    begin
      tens = c / 8'h0A;
      ones = c % 8'h0A;
      digits = {tens[3:0], ones[3:0]};
    end
  endfunction

  // priority encoded detection, highest priority cause per cycle
  always @* begin
    det_nxt = `CODE_NONE;
    if (freq_lock_fail_i)
      det_nxt = `CODE_LOCK;
    else if (vswr_high_i & auto_power_i)
      det_nxt = `CODE_VSWR;
    else if (fil_seq_i & recycle_over_i)
      det_nxt = `CODE_RECYC;
    else if (fil_seq_i & heater_off_button_i)
      det_nxt = `CODE_HOFF;
    else if (fil_seq_i & phase_open_i)
      det_nxt = `CODE_PHASE;
    else if (blower_on_i & ~air_closed_i & (cnt_air_r >= T_BLOWER_CYC))
      det_nxt = `CODE_AIR;
    else if (heater_power_on_i & ~heater_above_5v_i & (cnt_heat_r >= T_HEATER_CYC))
      det_nxt = `CODE_HEATV;
    else if (fil_seq_i & driver_stage_low_i)
      det_nxt = `CODE_DRV;
    else if (plate_seq_i & (heater_off_button_i | plate_off_button_i))
      det_nxt = `CODE_POFF;
    else if (plate_seq_i & ovld_open_i)
      det_nxt = `CODE_OVLD;
    else if (bias_on_i & ~bias_below_150_i & (cnt_bias_r >= T_BIAS_CYC))
      det_nxt = `CODE_BIAS;
    else if (step_only_i & plate_i_above_3a_i)
      det_nxt = `CODE_STEPI;
    else if (step_seq_i & (cnt_lowv_r >= T_LOWV_CYC))
      det_nxt = `CODE_LOWV;
    else if (run_i & (cnt_run_r >= T_BIASRUN_CYC))
      det_nxt = `CODE_BIASRUN;
  end

  // timers; counters saturate one past expiry so a held fault keeps reporting every cycle
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_air_r <= 32'h0;
      cnt_heat_r <= 32'h0;
      cnt_bias_r <= 32'h0;
      cnt_lowv_r <= 32'h0;
      cnt_run_r <= 32'h0;
      blower_d_r <= 1'b0;
      heat_d_r <= 1'b0;
      bias_d_r <= 1'b0;
    end else begin
      blower_d_r <= blower_on_i;
      heat_d_r <= heater_power_on_i;
      bias_d_r <= bias_on_i;
      if (blower_on_i & ~blower_d_r)
        cnt_air_r <= 32'h0;
      else if (blower_on_i & ~air_closed_i & (cnt_air_r <= T_BLOWER_CYC))
        cnt_air_r <= cnt_air_r + 32'h1;
      if (heater_power_on_i & ~heat_d_r)
        cnt_heat_r <= 32'h0;
      else if (heater_power_on_i & ~heater_above_5v_i & (cnt_heat_r <= T_HEATER_CYC))
        cnt_heat_r <= cnt_heat_r + 32'h1;
      if (bias_on_i & ~bias_d_r)
        cnt_bias_r <= 32'h0;
      else if (bias_on_i & ~bias_below_150_i & (cnt_bias_r <= T_BIAS_CYC))
        cnt_bias_r <= cnt_bias_r + 32'h1;
      if (~(step_seq_i & plate_v_below_6kv_i))
        cnt_lowv_r <= 32'h0;
      else if (cnt_lowv_r <= T_LOWV_CYC)
        cnt_lowv_r <= cnt_lowv_r + 32'h1;
      if (~(run_i & ~bias_below_150_i))
        cnt_run_r <= 32'h0;
      else if (cnt_run_r <= T_BIASRUN_CYC)
        cnt_run_r <= cnt_run_r + 32'h1;
    end
  end

  // latest cause register, no dependency on who holds operating control
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      code_r <= `CODE_NONE;
      fault_code_o <= `CODE_NONE;
      fault_stb_o <= 1'b0;
    end else begin
      fault_stb_o <= (det_nxt != `CODE_NONE);
      if (det_nxt != `CODE_NONE) begin
        code_r <= det_nxt;
        fault_code_o <= det_nxt;
      end
    end
  end

  // overload history, menu navigation, interrupt and apb slave
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (i = 0; i < `MENU_LAST; i = i + 1) begin
        wptr_r[i] <= 3'h0;
        cnt_r[i] <= 4'h0;
      end
      for (i = 0; i < `MENU_LAST*DEPTH; i = i + 1)
        hist_r[i] <= 16'h0;
      view_r <= 3'h0;
      menu_r <= 3'h0;
      clr_arm_r <= 1'b0;
      stat_r <= 2'h0;
      mask_r <= 2'h0;
      prdata_o <= 32'h0;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      menu_entry_o <= 3'h0;
      menu_value_o <= 16'h0;
      irq_o <= 1'b0;
    end else begin
      pready_o <= psel_i & ~penable_i;
      pslverr_o <= 1'b0;
      if (overload_stb_i && overload_type_i < `MENU_LAST) begin
        hist_r[overload_type_i*DEPTH+wptr_r[overload_type_i]] <= overload_evt_i;
        wptr_r[overload_type_i] <= wptr_r[overload_type_i] + 3'h1;
        if (cnt_r[overload_type_i] < DEPTH)
          cnt_r[overload_type_i] <= cnt_r[overload_type_i] + 4'h1;
      end
      if (key_wr) begin
        if (key[`KEY_CLR]) begin
          clr_arm_r <= ~clr_arm_r;
          if (clr_arm_r && menu_r < `MENU_LAST)
            cnt_r[menu_r] <= 4'h0;
        end else
          clr_arm_r <= 1'b0;
        if (key[`KEY_NEXT])
          menu_r <= (menu_r == `MENU_LAST) ? 3'h0 : menu_r + 3'h1;
        if (key[`KEY_PREV])
          view_r <= view_r + 3'h1;
        if (key[`KEY_SEL] | key[`KEY_NEXT] | key[`KEY_RET])
          view_r <= 3'h0;
      end
      if (menu_r == `MENU_CAUSE)
        menu_value_o <= {8'h0, digits(code_r)};
      else if ({1'b0, view_r} < cnt_r[menu_r])
        menu_value_o <= hist_r[menu_r*DEPTH + wptr_r[menu_r] - 3'h1 - view_r];
      else
        menu_value_o <= 16'h0;
      menu_entry_o <= menu_r;
      stat_r[0] <= stat_r[0] & ~(apb_wr & (paddr_i == `PADDR_STAT) & pwdata_i[0])
        | fault_stb_o;
      stat_r[1] <= stat_r[1] & ~(apb_wr & (paddr_i == `PADDR_STAT) & pwdata_i[1])
        | overload_stb_i;
      if (apb_wr & (paddr_i == `PADDR_MASK))
        mask_r <= pwdata_i[1:0];
      irq_o <= |(stat_r & mask_r);
      if (psel_i & ~penable_i & ~pwrite_i) begin
        case (paddr_i)
          `PADDR_CODE: prdata_o <= {24'h0, code_r};
          `PADDR_STAT: prdata_o <= {30'h0, stat_r};
          `PADDR_MASK: prdata_o <= {30'h0, mask_r};
          `PADDR_MENU: prdata_o <= {13'h0, menu_r, menu_value_o};
          `PADDR_EVT: prdata_o <= {28'h0, cnt_r[menu_r < `MENU_LAST ? menu_r : 3'h0]};
          default: prdata_o <= 32'h0;
        endcase
      end
      if (psel_i & ~penable_i && paddr_i != `PADDR_CODE && paddr_i != `PADDR_STAT &&
          paddr_i != `PADDR_MASK && paddr_i != `PADDR_MENU && paddr_i != `PADDR_EVT &&
          paddr_i != `PADDR_KEY)
        pslverr_o <= 1'b1;
    end
  end
endmodule // transmitter_fault_supervisor

// *** test/test_transmitter_fault_supervisor.sv ***
`timescale 1ns/1ps
module test_transmitter_fault_supervisor;
  logic ref_clk_i = 0, rst_n_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0, overload_stb_i = 0;
  logic [11:0] paddr_i = 0;
  logic [31:0] pwdata_i = 0, rdat;
  logic [15:0] overload_evt_i = 0;
  logic [2:0] overload_type_i = 0;
  logic [3:0] fsel = 0;
  logic perr;
  wire [31:0] prdata_o;
  wire pready_o, pslverr_o, fault_stb_o, irq_o;
  wire [7:0] fault_code_o;
  wire [2:0] menu_entry_o;
  wire [15:0] menu_value_o;
  wire fil_seq_i, plate_seq_i, step_seq_i, run_i, freq_lock_fail_i, vswr_high_i, auto_power_i;
  wire recycle_over_i, heater_off_button_i, plate_off_button_i, phase_open_i, blower_on_i;
  wire air_closed_i, heater_power_on_i, heater_above_5v_i, driver_stage_low_i, ovld_open_i;
  wire bias_on_i, bias_below_150_i, step_only_i, plate_i_above_3a_i, plate_v_below_6kv_i;
  int n_mismatch = 0, checked = 0, i;
  logic [7:0] exp_c [0:14] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h0A, 8'h0B, 8'h0C, 8'h0D,
    8'h0E, 8'h14, 8'h15, 8'h16, 8'h17, 8'h18, 8'h1E};
  transmitter_fault_supervisor #(.T_BLOWER_CYC(20), .T_HEATER_CYC(20), .T_BIAS_CYC(20),
    .T_LOWV_CYC(20), .T_BIASRUN_CYC(20)) uut (.*);
  tx_plant_model plant (.*);
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel_i <= 1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge ref_clk_i) penable_i <= 1;
    do begin
      @(posedge ref_clk_i);
      k++;
    end while (pready_o !== 1'b1 && k < 50);
    rdat = prdata_o;
    perr = pslverr_o;
    psel_i <= 0;
    penable_i <= 0;
    @(posedge ref_clk_i);
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task print_verdict;
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial forever #10 ref_clk_i = ~ref_clk_i;
  initial begin
    #200000;
    n_mismatch++;
    print_verdict;
  end
  initial begin
    repeat (12) @(posedge ref_clk_i);
    rst_n_i <= 1;
    @(posedge ref_clk_i);
    for (i = 1; i < 15; i++) begin
      fsel <= i[3:0];
      repeat (5) @(posedge ref_clk_i);
      apb(0, 12'h000, 0);
      chk("early code", exp_c[(i inside {6, 7, 11, 13, 14}) ? i - 1 : i], rdat);
      repeat (40) @(posedge ref_clk_i);
      apb(0, 12'h000, 0);
      chk("fault code", exp_c[i], rdat);
      fsel <= 0;
      repeat (3) @(posedge ref_clk_i);
      apb(0, 12'h000, 0);
      chk("held code", exp_c[i], rdat);
    end
    apb(0, 12'h004, 0);
    chk("status", 32'h00000001, rdat);
    apb(1, 12'h008, 32'h00000001);
    @(posedge ref_clk_i);
    chk("irq set", 1, irq_o);
    apb(1, 12'h008, 0);
    @(posedge ref_clk_i);
    chk("irq masked", 0, irq_o);
    apb(1, 12'h008, 32'h00000001);
    apb(1, 12'h004, 32'h00000001);
    @(posedge ref_clk_i);
    chk("irq cleared", 0, irq_o);
    apb(0, 12'h020, 0);
    chk("unmapped err", 1, perr);
    chk("unmapped data", 0, rdat);
    overload_type_i <= 3'h5;
    overload_evt_i <= 16'h1234;
    overload_stb_i <= 1;
    @(posedge ref_clk_i);
    overload_evt_i <= 16'h5678;
    @(posedge ref_clk_i);
    overload_stb_i <= 0;
    @(posedge ref_clk_i);
    for (i = 0; i < 8 && menu_entry_o !== 3'h5; i++) begin
      apb(1, 12'h014, 32'h00000001);
      @(posedge ref_clk_i);
    end
    chk("entry before cause", 5, menu_entry_o);
    apb(0, 12'h00C, 0);
    chk("newest event", {13'h0000, 3'h5, 16'h5678}, rdat);
    apb(1, 12'h014, 32'h00000002);
    apb(0, 12'h00C, 0);
    chk("older event", {13'h0000, 3'h5, 16'h1234}, rdat);
    apb(1, 12'h014, 32'h00000008);
    apb(0, 12'h010, 0);
    chk("count after one clear", 2, rdat);
    apb(1, 12'h014, 32'h00000008);
    apb(1, 12'h014, 32'h00000008);
    apb(0, 12'h010, 0);
    chk("count after two clears", 0, rdat);
    apb(1, 12'h014, 32'h00000001);
    @(posedge ref_clk_i);
    chk("cause entry", 6, menu_entry_o);
    apb(0, 12'h00C, 0);
    chk("cause menu", {13'h0000, 3'h6, 16'h0030}, rdat);
    print_verdict;
  end
endmodule // test_transmitter_fault_supervisor

// *** test/transmitter_fault_supervisor_props.sv ***
`timescale 1ns/1ps
module fault_supervisor_props (
  input wire ref_clk_i, rst_n_i, freq_lock_fail_i, vswr_high_i, auto_power_i, fil_seq_i,
  input wire plate_seq_i, recycle_over_i, heater_off_button_i, phase_open_i,
  input wire plate_off_button_i, fault_stb_o,
  input wire [7:0] fault_code_o,
  input wire [2:0] menu_entry_o,
  input wire [15:0] menu_value_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  wire hi = freq_lock_fail_i | (vswr_high_i & auto_power_i);
  wire fl = fil_seq_i & !hi & !recycle_over_i;
  wire [7:0] bcd = ((fault_code_o / 8'h0A) << 4) | (fault_code_o % 8'h0A);
  chk_lock_code: assert property (freq_lock_fail_i |=> fault_stb_o && fault_code_o == 8'h01)
    else $error("lock fault code wrong");
  chk_ratio_code: assert property (!freq_lock_fail_i && vswr_high_i && auto_power_i |=> fault_code_o == 8'h02)
    else $error("ratio fault code wrong");
  chk_recycle_code: assert property (fil_seq_i && !hi && recycle_over_i |=> fault_code_o == 8'h04)
    else $error("recycle fault code wrong");
  chk_heater_off: assert property (fl && heater_off_button_i |=> fault_code_o == 8'h0A)
    else $error("heater off code wrong");
  chk_phase_code: assert property (fl && !heater_off_button_i && phase_open_i |=> fault_code_o == 8'h0B)
    else $error("phase fault code wrong");
  chk_plate_off: assert property (plate_seq_i && !fil_seq_i && !hi && (heater_off_button_i || plate_off_button_i) |=> fault_code_o == 8'h14)
    else $error("plate off code wrong");
  chk_code_holds: assert property (!fault_stb_o |-> $stable(fault_code_o))
    else $error("code changed without fault");
  chk_cause_shown: assert property (menu_entry_o == 3'h6 && $past(menu_entry_o) == 3'h6 && $stable(fault_code_o) |-> menu_value_o == {8'h00, bcd})
    else $error("cause display wrong");
  cover property (fault_stb_o && fault_code_o == 8'h1E);
  cover property (fault_stb_o && fault_code_o == 8'h0C);
  cover property (menu_entry_o == 3'h6);
endmodule // fault_supervisor_props
bind transmitter_fault_supervisor fault_supervisor_props props_u (.*);

// *** test/tx_plant_model.sv ***
`timescale 1ns/1ps
module tx_plant_model (
  input wire [3:0] fsel,
  output wire fil_seq_i, plate_seq_i, step_seq_i, run_i, freq_lock_fail_i, vswr_high_i,
  output wire auto_power_i, recycle_over_i, heater_off_button_i, plate_off_button_i,
  output wire phase_open_i, blower_on_i, air_closed_i, heater_power_on_i, heater_above_5v_i,
  output wire driver_stage_low_i, ovld_open_i, bias_on_i, bias_below_150_i, step_only_i,
  output wire plate_i_above_3a_i, plate_v_below_6kv_i
);
  // one fault condition presented per selection, healthy plant at zero
  wire [15:0] f = 16'h0001 << fsel;
  assign freq_lock_fail_i = f[1];
  assign vswr_high_i = f[2];
  assign auto_power_i = f[2];
  assign fil_seq_i = |f[8:3];
  assign recycle_over_i = f[3];
  assign heater_off_button_i = f[4];
  assign phase_open_i = f[5];
  assign blower_on_i = f[6];
  assign air_closed_i = !f[6];
  assign heater_power_on_i = f[7];
  assign heater_above_5v_i = !f[7];
  assign driver_stage_low_i = f[8];
  assign plate_seq_i = |f[12:9];
  assign plate_off_button_i = f[9];
  assign ovld_open_i = f[10];
  assign bias_on_i = f[11];
  assign bias_below_150_i = !(f[11] | f[14]);
  assign step_only_i = f[12];
  assign plate_i_above_3a_i = f[12];
  assign step_seq_i = f[13];
  assign plate_v_below_6kv_i = f[13];
  assign run_i = f[14];
endmodule // tx_plant_model
